// ---- src/tal_params.svh ----
// Constants for the temperature alarm outputs block.
// Assumes inclusion by the design file only.
`ifndef TAL_PARAMS_SVH
`define TAL_PARAMS_SVH
`define TAL_OFS_OT_LIMIT 8'h20
`define TAL_OFS_OT_HYST 8'h21
`define TAL_RST_OT_LIMIT 8'h55
`define TAL_RST_OT_HYST 8'h0A
`define TAL_RES_10 2'b00
`define TAL_RES_11 2'b01
`define TAL_RES_12 2'b11
`define TAL_RES_9 2'b10
`define TAL_CLK_MHZ 200
`define TAL_CONV10_MS 21
`define TAL_CONV10_CYC (`TAL_CONV10_MS * `TAL_CLK_MHZ * 1000)
`define TAL_SENSE_CYC 16
`endif

// ---- src/tal_pkg.sv ----
// Types for the temperature alarm outputs block.
// Assumes the constants header is on the include path.
package tal_pkg;
   // Register write request from the SMBus engine
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } tal_wr_t;
   typedef enum logic [1:0] {TAL_SENSE, TAL_IDLE, TAL_CONV} tal_state_t;
endpackage : tal_pkg

// ---- src/tal_alarm.sv ----
// Limit alert and over-temperature outputs of the temperature sensor.
// Assumes an SMBus engine on clk feeding register writes and ARA acknowledges,
// and an ADC reading on the link clock with a done pulse per conversion.
// Functional notes
// R1 - Alert low while reading above high limit or at/below low limit.
// R2 - Alert stays latched until host ARA read is acknowledged.
// R3 - Alert released at the ARA acknowledge with own address.
// R4 - Alert reasserts at next conversion end if still out of window.
// R5 - Over-temp output low while temperature exceeds limit at 20h.
// R6 - Over-temp compare uses only upper 8 bits of reading.
// R7 - Over-temp holds until temperature at or below limit minus hysteresis.
// R8 - Address pin sensed at power-up to pick slave address, then alarm.
// R9 - Resolution programmable 9 to 12 bits, 0.5 to 0.0625 per LSB.
// R10 - Over-temp limit 8-bit two's complement, resets to 85.
// R11 - Hysteresis register at 21h, 8-bit two's complement, resets to 10.
// R12 - Conversion time doubles per bit; alarms evaluated once per conversion.
`timescale 1ns/10ps
`include "tal_params.svh"
module tal_alarm #(
   parameter int CONV_BASE_CYC = `TAL_CONV10_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic adc_clk,
   input wire logic [15:0] adc_temp,
   input wire logic adc_done,
   input wire tal_pkg::tal_wr_t reg_wr,
   input wire logic [1:0] res_sel,
   input wire logic [15:0] high_limit,
   input wire logic [15:0] low_limit,
   input wire logic ara_ack,
   input wire logic addr_pin_in,
   output logic alert_n_o,
   output logic alert_n_oe,
   output logic ot_n_o,
   output logic ot_n_oe,
   output logic addr_sel,
   output logic addr_valid,
   output logic [7:0] ot_limit_rd,
   output logic [7:0] ot_hyst_rd,
   output logic [15:0] temp_rd,
   output logic conv_start
);
   // ==========================================
   // Functions
   function automatic logic [15:0] res_mask(input logic [1:0] r);
      case (r)
         `TAL_RES_9: res_mask = 16'hFF80;
         `TAL_RES_11: res_mask = 16'hFFE0;
         `TAL_RES_12: res_mask = 16'hFFF0;
         default: res_mask = 16'hFFC0;
      endcase
   endfunction : res_mask

   function automatic logic [31:0] conv_cyc(input logic [1:0] r);
      case (r)
         `TAL_RES_9: conv_cyc = 32'(CONV_BASE_CYC / 2);
         `TAL_RES_11: conv_cyc = 32'(CONV_BASE_CYC * 2);
         `TAL_RES_12: conv_cyc = 32'(CONV_BASE_CYC * 4);
         default: conv_cyc = 32'(CONV_BASE_CYC);
      endcase
   endfunction : conv_cyc

   // ==========================================
   // Link domain capture
   logic [15:0] adc_temp_q;
   logic done_tgl_q;
   always_ff @(posedge adc_clk or posedge rst) begin
      if (rst) begin
         adc_temp_q <= 16'h0000;
         done_tgl_q <= 1'b0;
      end else if (adc_done) begin
         adc_temp_q <= adc_temp;
         done_tgl_q <= ~done_tgl_q;
      end
   end

   // Toggle crossing; data is stable long before the toggle lands
   logic done_s1_q, done_s2_q, done_s3_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done_s1_q <= 1'b0;
         done_s2_q <= 1'b0;
         done_s3_q <= 1'b0;
      end else begin
         done_s1_q <= done_tgl_q;
         done_s2_q <= done_s1_q;
         done_s3_q <= done_s2_q;
      end
   end
   logic conv_done;
   assign conv_done = done_s2_q ^ done_s3_q;

   // ==========================================
   // Power-up address sensing
   logic pin_s1_q, pin_s2_q, pin_s3_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_s1_q <= 1'b1;
         pin_s2_q <= 1'b1;
         pin_s3_q <= 1'b1;
      end else begin
         pin_s1_q <= addr_pin_in;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   tal_pkg::tal_state_t state_q;
   logic [4:0] sense_cnt_q;
   logic [31:0] conv_cnt_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= tal_pkg::TAL_SENSE;
         sense_cnt_q <= 5'h00;
         addr_sel <= 1'b0;
         addr_valid <= 1'b0;
         conv_cnt_q <= 32'h0000_0000;
         conv_start <= 1'b0;
      end else begin
         conv_start <= 1'b0;
         case (state_q)
            tal_pkg::TAL_SENSE: begin
               // Pin stays undriven until the strap is caught
               if (pin_s2_q == pin_s3_q) begin
                  sense_cnt_q <= sense_cnt_q + 5'h01;
               end else begin
                  sense_cnt_q <= 5'h00;
               end
               if (sense_cnt_q == 5'(`TAL_SENSE_CYC)) begin
                  addr_sel <= pin_s3_q; // see R8
                  addr_valid <= 1'b1;
                  state_q <= tal_pkg::TAL_IDLE;
               end
            end
            // Count from one less so a period is exactly conv_cyc cycles
            tal_pkg::TAL_IDLE: begin
               conv_start <= 1'b1;
               conv_cnt_q <= conv_cyc(res_sel) - 32'h0000_0001; // see R12
               state_q <= tal_pkg::TAL_CONV;
            end
            // Back to back starts; a resolution change lands at the next start
            tal_pkg::TAL_CONV: begin
               if (conv_cnt_q != 32'h0000_0000) begin
                  conv_cnt_q <= conv_cnt_q - 32'h0000_0001;
               end else begin
                  conv_start <= 1'b1;
                  conv_cnt_q <= conv_cyc(res_sel) - 32'h0000_0001; // see R12
               end
            end
            default: state_q <= tal_pkg::TAL_SENSE;
         endcase
      end
   end

   // ==========================================
   // Registers
   // Other offsets belong to the rest of the register file
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ot_limit_rd <= `TAL_RST_OT_LIMIT; // see R10
         ot_hyst_rd <= `TAL_RST_OT_HYST; // see R11
      end else if (reg_wr.wr) begin
         if (reg_wr.addr == `TAL_OFS_OT_LIMIT) ot_limit_rd <= reg_wr.data; // see R5
         if (reg_wr.addr == `TAL_OFS_OT_HYST) ot_hyst_rd <= reg_wr.data; // see R11
      end
   end

   // ==========================================
   // Alarm evaluation, once per conversion
   logic [15:0] temp_now;
   logic out_win;
   logic signed [8:0] ot_release;
   assign temp_now = adc_temp_q & res_mask(res_sel); // see R9
   assign out_win = ($signed(temp_now) > $signed(high_limit))
                  || ($signed(temp_now) <= $signed(low_limit)); // see R1
   assign ot_release = $signed({ot_limit_rd[7], ot_limit_rd})
                     - $signed({ot_hyst_rd[7], ot_hyst_rd});

   logic alert_q, ot_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         temp_rd <= 16'h0000;
         alert_q <= 1'b0;
      end else begin
         if (conv_done) temp_rd <= temp_now;
         // Acknowledge releases; a new conversion in the same cycle wins
         if (conv_done && out_win) begin
            alert_q <= 1'b1; // see R1, R4
         end else if (ara_ack && alert_q) begin
            alert_q <= 1'b0; // see R2, R3
         end
      end
   end

   // Fresh readings only, so a limit write acts at the next conversion
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ot_q <= 1'b0;
      end else if (conv_done) begin
         if ($signed(temp_now[15:8]) > $signed(ot_limit_rd)) begin // see R5, R6
            ot_q <= 1'b1;
         end else if ($signed({temp_now[15], temp_now[15:8]}) <= ot_release) begin
            ot_q <= 1'b0; // see R7
         end
      end
   end

   // ==========================================
   // Open-drain pins: output always low, enable drives
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         alert_n_o <= 1'b0;
         alert_n_oe <= 1'b0;
         ot_n_o <= 1'b0;
         ot_n_oe <= 1'b0;
      end else begin
         alert_n_o <= 1'b0;
         ot_n_o <= 1'b0;
         alert_n_oe <= (conv_done && out_win) || (alert_q && !ara_ack);
         ot_n_oe <= ot_q && addr_valid; // see R8
      end
   end
endmodule : tal_alarm

// ---- tb/tal_alarm_props.sv ----
// Checker for the alarm outputs.
// Assumes it is bound into tal_alarm and sees only its ports.
`timescale 1ns/10ps
module tal_alarm_props (
   input wire logic clk,
   input wire logic rst,
   input wire tal_pkg::tal_wr_t reg_wr,
   input wire logic [15:0] high_limit,
   input wire logic [15:0] low_limit,
   input wire logic ara_ack,
   input wire logic alert_n_o,
   input wire logic alert_n_oe,
   input wire logic ot_n_o,
   input wire logic ot_n_oe,
   input wire logic addr_valid,
   input wire logic [7:0] ot_limit_rd,
   input wire logic [7:0] ot_hyst_rd,
   input wire logic [15:0] temp_rd
);
   // ==========
   // Properties
   wire logic out_w = $signed(temp_rd) > $signed(high_limit) ||
      $signed(temp_rd) <= $signed(low_limit);
   // Nine bits, so limit minus hysteresis cannot wrap
   wire logic signed [8:0] rel_w = $signed({ot_limit_rd[7], ot_limit_rd}) -
      $signed({ot_hyst_rd[7], ot_hyst_rd});
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_ack;
      ara_ack && alert_n_oe;
   endsequence
   a_alert_release: assert property (s_ack |=> !alert_n_oe || out_w)
      else $error("alert not released");
   a_alert_latch: assert property (alert_n_oe && !ara_ack |=> alert_n_oe)
      else $error("alert dropped");
   a_alert_cause: assert property ($rose(alert_n_oe) |-> out_w)
      else $error("alert without cause");
   a_open_drain: assert property (!alert_n_o && !ot_n_o)
      else $error("pin driven high");
   a_ot_cause: assert property ($rose(ot_n_oe) |->
      $signed(temp_rd[15:8]) > $signed(ot_limit_rd))
      else $error("over-temp without cause");
   a_ot_hyst: assert property ($fell(ot_n_oe) |->
      $signed({temp_rd[15], temp_rd[15:8]}) <= rel_w)
      else $error("over-temp released early");
   a_lim_write: assert property (reg_wr.wr && reg_wr.addr == 8'h20 |=>
      ot_limit_rd == $past(reg_wr.data))
      else $error("limit write lost");
   a_hyst_write: assert property (reg_wr.wr && reg_wr.addr == 8'h21 |=>
      ot_hyst_rd == $past(reg_wr.data))
      else $error("hysteresis write lost");
   a_regs_hold: assert property (!reg_wr.wr |=>
      $stable(ot_limit_rd) && $stable(ot_hyst_rd))
      else $error("register changed");
   a_strap_first: assert property (!addr_valid |-> !ot_n_oe)
      else $error("pin driven during strap");
endmodule : tal_alarm_props
bind tal_alarm tal_alarm_props u_props (.clk, .rst, .reg_wr, .high_limit, .low_limit,
   .ara_ack, .alert_n_o, .alert_n_oe, .ot_n_o, .ot_n_oe, .addr_valid, .ot_limit_rd,
   .ot_hyst_rd, .temp_rd);

// ---- tb/tal_adc_model.sv ----
// ADC model on the link clock.
// Assumes conv_start pulses on clk; answers each with one done pulse.
`timescale 1ns/10ps
module tal_adc_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic adc_clk,
   input wire logic conv_start,
   input wire logic [15:0] reading,
   output logic [15:0] adc_temp,
   output logic adc_done
);
   logic tog_q;
   logic [2:0] sync_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) tog_q <= 1'b0;
      else if (conv_start) tog_q <= ~tog_q;
   end
   // Toggle crossing, a one-clk start is never lost
   always_ff @(posedge adc_clk or posedge rst) begin
      if (rst) sync_q <= 3'h0;
      else sync_q <= {sync_q[1:0], tog_q};
   end
   assign adc_done = sync_q[2] ^ sync_q[1];
   // Data is junk outside the done pulse
   assign adc_temp = adc_done ? reading : ~reading;
endmodule : tal_adc_model

// ---- tb/tal_alarm_test.sv ----
// Bench for the alarm outputs block.
// Assumes the ADC model and the checker bind are compiled alongside.
`timescale 1ns/10ps
`define CHK(n, e, v) begin checks_done++; if ((v) !== (e)) begin error_cnt++; \
   $display("wrong value %s exp %h got %h", n, e, v); end end
module tal_alarm_test;
   logic clk = 0, rst = 1, adc_clk = 0, ara_ack = 0, adc_done;
   logic [15:0] reading = 16'h1400, adc_temp, temp_rd;
   logic [15:0] high_limit = 16'h1E00, low_limit = 16'h0A00;
   tal_pkg::tal_wr_t reg_wr = '0;
   logic [1:0] res_sel = 2'b00;
   logic alert_n_oe, ot_n_oe, addr_sel, addr_valid, conv_start;
   logic alert_n_o, ot_n_o;
   logic strap_lo = 1'b0;
   logic [7:0] ot_limit_rd, ot_hyst_rd;
   int error_cnt = 0, checks_done = 0, n;
   logic [15:0] tv[5] = '{16'h1400, 16'h19F0, 16'h1A00, 16'h1000, 16'h0F00};
   logic ov[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   logic [1:0] rc[4] = '{2'b10, 2'b00, 2'b01, 2'b11};
   // Strap reads its resistor's level unless the block pulls low
   wire logic addr_pin_in = (ot_n_oe || strap_lo) ? 1'b0 : 1'b1;
   tal_alarm #(.CONV_BASE_CYC(50)) dut (.clk, .rst, .adc_clk, .adc_temp, .adc_done,
      .reg_wr, .res_sel, .high_limit, .low_limit, .ara_ack, .addr_pin_in,
      .alert_n_o, .alert_n_oe, .ot_n_o, .ot_n_oe, .addr_sel, .addr_valid,
      .ot_limit_rd, .ot_hyst_rd, .temp_rd, .conv_start);
   tal_adc_model adc (.clk, .rst, .adc_clk, .conv_start, .reading, .adc_temp, .adc_done);
   initial forever #2.5 clk = ~clk;
   initial begin
      #1.3;
      forever #7.5 adc_clk = ~adc_clk;
   end
   // ==========
   // Tasks
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) reg_wr <= '{1'b1, a, d};
      @(posedge clk) reg_wr.wr <= 1'b0;
      @(posedge clk) #1;
   endtask : wr
   task ara;
      @(posedge clk) ara_ack <= 1'b1;
      @(posedge clk) ara_ack <= 1'b0;
      @(posedge clk) #1;
   endtask : ara
   // Samples one step after the edge, once the pulse has settled
   task per;
      do begin
         @(posedge clk);
         #1;
      end while (conv_start !== 1'b1);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (conv_start !== 1'b1);
   endtask : per
   task conv(input logic [15:0] v);
      @(posedge clk) reading <= v;
      per;
      per;
      repeat (3) @(posedge clk);
      #1;
   endtask : conv
   task close_out;
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   initial begin
      #200000;
      error_cnt++;
      close_out;
   end
   // ==========
   // Tests
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      #1;
      `CHK("limit", 8'h55, ot_limit_rd)
      `CHK("hyst", 8'h0A, ot_hyst_rd)
      wr(8'h21, 8'h05);
      `CHK("hyst", 8'h05, ot_hyst_rd)
      wr(8'h20, 8'h19);
      wr(8'h21, 8'h0A);
      wr(8'h22, 8'h00);
      `CHK("limit", 8'h19, ot_limit_rd)
      `CHK("hyst", 8'h0A, ot_hyst_rd)
      conv(16'h1400);
      `CHK("strap", 2'b11, {addr_valid, addr_sel})
      for (int i = 0; i < 5; i++) begin
         conv(tv[i]);
         `CHK("ot", ov[i], ot_n_oe)
      end
      conv(16'h1E00);
      `CHK("alert", 1'b0, alert_n_oe)
      conv(16'h1E40);
      `CHK("alert", 1'b1, alert_n_oe)
      ara;
      `CHK("alert", 1'b0, alert_n_oe)
      conv(16'h1E40);
      `CHK("alert", 1'b1, alert_n_oe)
      conv(16'h1400);
      `CHK("alert", 1'b1, alert_n_oe)
      ara;
      conv(16'h1400);
      `CHK("alert", 1'b0, alert_n_oe)
      conv(16'h0A00);
      `CHK("alert", 1'b1, alert_n_oe)
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) res_sel <= rc[i];
         conv(16'h127F);
         per;
         `CHK("temp", 16'h127F & (16'hFFF0 << (3 - i)), temp_rd)
         `CHK("period", 25 << i, n)
      end
      `CHK("pins", 2'b00, {alert_n_o, ot_n_o})
      // Second power-up, this time with a pull-down strap
      @(posedge clk) begin
         rst <= 1'b1;
         strap_lo <= 1'b1;
      end
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      #1;
      `CHK("limit", 8'h55, ot_limit_rd)
      `CHK("strap", 2'b00, {addr_valid, addr_sel})
      repeat (30) @(posedge clk);
      #1;
      `CHK("strap", 2'b10, {addr_valid, addr_sel})
      `CHK("ot", 1'b0, ot_n_oe)
      close_out;
   end
endmodule : tal_alarm_test
